// ==== rtl/sebsw_map.vh ====
`ifndef SEBSW_MAP_VH
`define SEBSW_MAP_VH

// ----------------------------------------
// control byte layout
// ----------------------------------------
`define SEBSW_CTRL_TYPE_MSB 7
`define SEBSW_CTRL_TYPE_LSB 4
`define SEBSW_CTRL_CS_MSB   3
`define SEBSW_CTRL_CS_LSB   1
`define SEBSW_CTRL_RW_BIT   0

// ----------------------------------------
// array and page geometry
// ----------------------------------------
`define SEBSW_ADDR_W        12
`define SEBSW_PAGE_W        5
`define SEBSW_PAGE_BYTES    32
`define SEBSW_HI_ADDR_BITS  4

// ----------------------------------------
// reset values
// ----------------------------------------
`define SEBSW_PTR_RST       12'h000
`define SEBSW_BYTE_RST      8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define SEBSW_TWC_MS        5
`define SEBSW_CORE_KHZ      200000
// longest time: exact product, no rounding
`define SEBSW_TWC_CLKS      (`SEBSW_TWC_MS * `SEBSW_CORE_KHZ)

`endif

// ==== rtl/sebsw_sync.v ====
`timescale 1ns/10ps
module sebsw_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         clk,
	input  wire         srst,
	// asynchronous levels in, synchronised levels out
	input  wire [W-1:0] d_in,
	output reg  [W-1:0] q_out
);
	reg [W-1:0] meta_r;

	// idle bus is high, so the lines reset high
	always @(posedge clk)
	begin
		if (srst)
		begin
			meta_r <= {W{1'b1}};
			q_out  <= {W{1'b1}};
		end
		else
		begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule

// ==== rtl/sebsw_top.v ====
`timescale 1ns/10ps
`include "sebsw_map.vh"

// What this block does
// - data changes only while clock is low; high-phase changes mean start or stop
// - start is data falling with clock high; detected at any time
// - stop is data rising with clock high; it closes the transaction
// - one clock pulse per bit; bit sampled on the clock high phase
// - over-long writes keep only the newest 32 bytes, oldest replaced first
// - control, address and write-data bytes are acknowledged on a ninth clock pulse; bytes after a read or a rejected control byte are not
// - no acknowledge at all while the write cycle runs
// - acknowledge holds data low through the whole ninth high phase
// - after a withheld read acknowledge the data line is left released
// - first byte after start: type code, chip selects two-one-zero, direction
// - acknowledge control byte only on type and chip-select match
// - direction bit one means read, zero means write
// - two address bytes, high first; top four bits of high byte ignored
// - byte write: control, two address bytes, data, stop starts write cycle
// - write protect high: acknowledge all, write nothing, stay ready
// - after a write the pointer sits just past the last written byte
// - short writes rewrite the whole page, refreshing untouched bytes
// - up to 31 more bytes buffered, committed only after stop
// - each data byte increments only the low five pointer bits
// - writes past a page end wrap to the page start
// - chip selects extend the address; pointer never carries into them
// - write protect sampled at stop; later changes do not matter
// - write cycle ends within 5 ms, then acknowledges resume
module sebsw_top #(
	parameter        WR_CYCLE_CLKS = `SEBSW_TWC_CLKS,
	// device type code: value is arbitrary
	parameter [3:0]  DEV_TYPE      = 4'h5
) (
	// clock and reset
	input  wire        CORE_CLK,
	input  wire        SRST,
	// two-wire bus pins
	input  wire        SCL_IN,
	input  wire        SDA_IN,
	output reg         SDA_OUT,
	output reg         SDA_OE_N,
	// straps
	input  wire [2:0]  CHIP_SEL,
	input  wire        WP_IN,
	// array read port
	input  wire [11:0] RD_ADDR,
	output reg  [7:0]  RD_DATA,
	// status
	output reg  [11:0] ADDR_PTR,
	output reg  [2:0]  EXT_ADDR,
	output reg         READ_SEL,
	output reg         WR_BUSY
);
	// ----------------------------------------
	// local constants
	// ----------------------------------------
	localparam AW   = `SEBSW_ADDR_W;
	localparam PW   = `SEBSW_PAGE_W;
	localparam PB   = `SEBSW_PAGE_BYTES;
	localparam CW   = $clog2(WR_CYCLE_CLKS + 1);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_CTRL = 3'h1;
	localparam [2:0] ST_AHI  = 3'h2;
	localparam [2:0] ST_ALO  = 3'h3;
	localparam [2:0] ST_DATA = 3'h4;
	localparam [2:0] ST_SKIP = 3'h5;

	// ----------------------------------------
	// control byte decode
	// ----------------------------------------
	function ctrl_match;
		input [7:0] b;
		input [2:0] cs;
		begin
			ctrl_match = (b[`SEBSW_CTRL_TYPE_MSB:`SEBSW_CTRL_TYPE_LSB] == DEV_TYPE)
				&& (b[`SEBSW_CTRL_CS_MSB:`SEBSW_CTRL_CS_LSB] == cs);
		end
	endfunction

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	wire [5:0] sync_q;
	wire       scl_s;
	wire       sda_s;
	wire [2:0] cs_s;
	wire       wp_s;

	sebsw_sync #(
		.W (6)
	) u_sync (
		.clk   (CORE_CLK),
		.srst  (SRST),
		.d_in  ({WP_IN, CHIP_SEL, SDA_IN, SCL_IN}),
		.q_out (sync_q)
	);

	assign scl_s = sync_q[0];
	assign sda_s = sync_q[1];
	assign cs_s  = sync_q[4:2];
	assign wp_s  = sync_q[5];

	// ----------------------------------------
	// line conditions
	// ----------------------------------------
	reg scl_d_r;
	reg sda_d_r;

	always @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	wire scl_rise = scl_s && !scl_d_r;
	wire scl_fall = !scl_s && scl_d_r;
	wire start_c  = scl_s && scl_d_r && sda_d_r && !sda_s;
	wire stop_c   = scl_s && scl_d_r && !sda_d_r && sda_s;

	// ----------------------------------------
	// write cycle timer
	// ----------------------------------------
	wire          busy;
	wire [CW-1:0] wcnt;
	reg           commit_r;

	sebsw_wtimer #(
		.N  (WR_CYCLE_CLKS),
		.CW (CW)
	) u_wtimer (
		.clk   (CORE_CLK),
		.srst  (SRST),
		.start (commit_r),
		.busy  (busy),
		.cnt   (wcnt)
	);

	// ----------------------------------------
	// framing and protocol state
	// ----------------------------------------
	reg [2:0]    state_r;
	reg [3:0]    bit_r;
	reg [7:0]    shift_r;
	reg          ack_ph_r;
	reg [3:0]    ahi_r;
	reg          have_r;
	reg [PB-1:0] mask_r;
	reg [AW-1:0] ptr_r;
	reg [7:0]    pbuf [0:PB-1];
	reg [AW-PW-1:0] page_r;

	wire [7:0] byte_in = shift_r;
	wire [PW-1:0] lo = ptr_r[PW-1:0];

	// ----------------------------------------
	// page slot arithmetic
	// ----------------------------------------
	// the slot index is five bits wide, so the sum drops its carry and the
	// pointer wraps inside the page instead of walking into the next one
	function [PW-1:0] slot_next;
		input [PW-1:0] s;
		begin
			slot_next = s + {{(PW-1){1'b0}}, 1'b1};
		end
	endfunction

	// ----------------------------------------
	// acknowledge decision
	// ----------------------------------------
	// the busy timer wins over any match: polling masters see silence
	wire       ctrl_ok   = ctrl_match(byte_in, cs_s);
	wire       ack_ctrl  = ctrl_ok && !busy;
	wire       ctrl_read = byte_in[`SEBSW_CTRL_RW_BIT];
	wire [2:0] ext_sel   = byte_in[`SEBSW_CTRL_CS_MSB:`SEBSW_CTRL_CS_LSB];

	// ----------------------------------------
	// write decision at stop
	// ----------------------------------------
	// the protect pin only counts at the stop itself; a later change cannot
	// touch a commit that is already under way
	wire in_data   = (state_r == ST_DATA);
	wire wr_ready  = in_data && have_r;
	wire wr_allow  = !wp_s && !busy;
	wire do_commit = stop_c && wr_ready && wr_allow;

	always @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			state_r  <= ST_IDLE;
			bit_r    <= 4'h0;
			shift_r  <= `SEBSW_BYTE_RST;
			ack_ph_r <= 1'b0;
			ahi_r    <= 4'h0;
			have_r   <= 1'b0;
			mask_r   <= {PB{1'b0}};
			ptr_r    <= `SEBSW_PTR_RST;
			page_r   <= {(AW-PW){1'b0}};
			commit_r <= 1'b0;
			SDA_OUT  <= 1'b0;
			SDA_OE_N <= 1'b1;
			READ_SEL <= 1'b0;
			EXT_ADDR <= 3'h0;
		end
		else
		begin
			commit_r <= 1'b0;
			if (start_c)
			begin
				// a restart ends any write without committing it
				state_r  <= ST_CTRL;
				bit_r    <= 4'h0;
				ack_ph_r <= 1'b0;
				have_r   <= 1'b0;
				SDA_OE_N <= 1'b1;
				READ_SEL <= 1'b0;
			end
			else if (stop_c)
			begin
				if (do_commit)
				begin
					commit_r <= 1'b1;
					page_r   <= ptr_r[AW-1:PW];
				end
				// protected writes are simply dropped: ready at once
				state_r  <= ST_IDLE;
				have_r   <= 1'b0;
				ack_ph_r <= 1'b0;
				SDA_OE_N <= 1'b1;
				READ_SEL <= 1'b0;
			end
			else if (state_r != ST_IDLE && scl_rise && !ack_ph_r)
			begin
				shift_r <= {shift_r[6:0], sda_s};
				bit_r   <= bit_r + 4'h1;
			end
			else if (state_r != ST_IDLE && scl_fall)
			begin
				if (ack_ph_r)
				begin
					// ninth pulse over: let go of the line
					ack_ph_r <= 1'b0;
					bit_r    <= 4'h0;
					SDA_OE_N <= 1'b1;
				end
				else if (bit_r == 4'h8)
				begin
					ack_ph_r <= 1'b1;
					case (state_r)
						ST_CTRL:
						begin
							if (ack_ctrl)
							begin
								SDA_OE_N <= 1'b0;
								EXT_ADDR <= ext_sel;
								if (ctrl_read)
								begin
									READ_SEL <= 1'b1;
									state_r  <= ST_SKIP;
								end
								else
									state_r  <= ST_AHI;
							end
							else
								state_r <= ST_SKIP;
						end
						ST_AHI:
						begin
							ahi_r    <= byte_in[3:0];
							SDA_OE_N <= 1'b0;
							state_r  <= ST_ALO;
						end
						ST_ALO:
						begin
							ptr_r    <= {ahi_r, byte_in};
							mask_r   <= {PB{1'b0}};
							SDA_OE_N <= 1'b0;
							state_r  <= ST_DATA;
						end
						ST_DATA:
						begin
							// newest byte overwrites the same slot: fifo order
							pbuf[lo]   <= byte_in;
							mask_r[lo] <= 1'b1;
							have_r     <= 1'b1;
							// low bits only: no carry into the page number
							ptr_r[PW-1:0] <= slot_next(lo);
							SDA_OE_N   <= 1'b0;
						end
						default:
							SDA_OE_N <= 1'b1;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// array and page commit
	// ----------------------------------------
	// the pointer is 12 bits wide, so it can never roll into the chip select
	// bits; reaching the next device needs a new control byte
	reg [7:0]    mem [0:(1<<AW)-1];
	wire         cm_on  = busy && (wcnt < PB);
	wire [PW-1:0] cm_ix = wcnt[PW-1:0];
	wire [AW-1:0] cm_a  = {page_r, cm_ix};

	// whole page is rewritten: unmarked bytes get their own old value back
	always @(posedge CORE_CLK)
	begin
		if (cm_on)
			mem[cm_a] <= mask_r[cm_ix] ? pbuf[cm_ix] : mem[cm_a];
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	always @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			RD_DATA  <= `SEBSW_BYTE_RST;
			ADDR_PTR <= `SEBSW_PTR_RST;
			WR_BUSY  <= 1'b0;
		end
		else
		begin
			RD_DATA  <= mem[RD_ADDR];
			ADDR_PTR <= ptr_r;
			WR_BUSY  <= busy || commit_r;
		end
	end
endmodule

// ==== rtl/sebsw_wtimer.v ====
`timescale 1ns/10ps
module sebsw_wtimer #(
	parameter N  = 1000000,
	parameter CW = 20
) (
	// clock and reset
	input  wire          clk,
	input  wire          srst,
	// control
	input  wire          start,
	// status
	output reg           busy,
	output reg  [CW-1:0] cnt
);
	localparam [CW-1:0] LAST = N - 1;

	always @(posedge clk)
	begin
		if (srst)
		begin
			busy <= 1'b0;
			cnt  <= {CW{1'b0}};
		end
		else if (start && !busy)
		begin
			busy <= 1'b1;
			cnt  <= {CW{1'b0}};
		end
		else if (busy)
		begin
			if (cnt == LAST)
				busy <= 1'b0;
			cnt <= cnt + 1'b1;
		end
	end
endmodule

// ==== verification/sebsw_chk.sv ====
`timescale 1ns/10ps
module sebsw_chk #(
	parameter WR_CYCLE_CLKS = 400
) (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        SRST,
	// bus pins
	input wire logic        SCL_IN,
	input wire logic        SDA_IN,
	input wire logic        SDA_OUT,
	input wire logic        SDA_OE_N,
	// status
	input wire logic [11:0] ADDR_PTR,
	input wire logic        READ_SEL,
	input wire logic        WR_BUSY
);
	// wide enough for the full 5 ms count
	logic [19:0] busy_cnt_r;
	always_ff @(posedge CORE_CLK)
		busy_cnt_r <= (SRST || !WR_BUSY) ? 20'h0_0000 : busy_cnt_r + 20'h0_0001;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	// ----
	// properties
	// ----
	property p_busy_mute; WR_BUSY |-> SDA_OE_N; endproperty
	a_busy_mute: assert property (p_busy_mute) else $error("ack while busy");
	property p_drive_low; !SDA_OE_N |-> !SDA_OUT; endproperty
	a_drive_low: assert property (p_drive_low) else $error("ack not low");
	property p_ack_hold; !SDA_OE_N && SCL_IN |=> !SDA_OE_N; endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
	// the pin is sampled raw, so the check keeps the sync lag on our side
	property p_ack_edge; $changed(SDA_OE_N) |-> !SCL_IN; endproperty
	a_ack_edge: assert property (p_ack_edge) else $error("data moved, clock high");
	// the status flag also covers the stop-time commit cycle ahead of the timer
	property p_busy_len; $fell(WR_BUSY) |-> busy_cnt_r == 20'(WR_CYCLE_CLKS + 1); endproperty
	a_busy_len: assert property (p_busy_len) else $error("bad write length");
	property p_busy_idle; $rose(WR_BUSY) |-> SCL_IN && SDA_IN; endproperty
	a_busy_idle: assert property (p_busy_idle) else $error("write not after stop");
	property p_rd_free; $rose(READ_SEL) |-> !WR_BUSY; endproperty
	a_rd_free: assert property (p_rd_free) else $error("read taken while busy");
	property p_ptr_hold; WR_BUSY && $past(WR_BUSY) |-> $stable(ADDR_PTR); endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved in write");
endmodule

// ==== verification/sebsw_mstr.sv ====
`timescale 1ns/10ps
module sebsw_mstr (
	// bus lines; one releases the line
	output logic      scl_o,
	output logic      sda_o,
	// resolved data line
	input  wire logic sda_i
);
	logic ack_v;
	event done;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic start;
		sda_o = 1'b1;
		#40 scl_o = 1'b1;
		#40 sda_o = 1'b0;
		#40 scl_o = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			#40 sda_o = b[i];
			#40 scl_o = 1'b1;
			#80 scl_o = 1'b0;
		end
		#40 sda_o = 1'b1;
		#40 scl_o = 1'b1;
		#40 ack_v = !sda_i;
		#40 scl_o = 1'b0;
		-> done;
	endtask
	task automatic stop;
		#40 sda_o = 1'b0;
		#40 scl_o = 1'b1;
		#40 sda_o = 1'b1;
		#80;
	endtask
endmodule

// ==== verification/sebsw_top_tb.sv ====
`timescale 1ns/10ps
bind sebsw_top sebsw_chk #(.WR_CYCLE_CLKS(WR_CYCLE_CLKS)) sebsw_chk_i (
	.CORE_CLK(CORE_CLK), .SRST(SRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ADDR_PTR(ADDR_PTR),
	.READ_SEL(READ_SEL), .WR_BUSY(WR_BUSY));
module sebsw_top_tb;
	// arbitrary type code
	localparam logic [3:0] DT = 4'h5;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        scl, sda_m, oe_n, sda_o, rsel, busy;
	logic [2:0]  cs = 3'h0;
	logic [2:0]  ext;
	logic        wp = 1'b0;
	logic [11:0] rd_addr = 12'h000;
	logic [11:0] ptr;
	logic [7:0]  rd_data, d0;
	logic [7:0]  pg [32];
	logic        q [$];
	int          fail_count = 0;
	int          comparisons = 0;
	// pull-up: released line reads high
	wire         sda = sda_m & (oe_n | sda_o);
	sebsw_top #(.WR_CYCLE_CLKS(400), .DEV_TYPE(DT)) sebsw_top_i (
		.CORE_CLK(clk), .SRST(srst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o),
		.SDA_OE_N(oe_n), .CHIP_SEL(cs), .WP_IN(wp), .RD_ADDR(rd_addr),
		.RD_DATA(rd_data), .ADDR_PTR(ptr), .EXT_ADDR(ext), .READ_SEL(rsel),
		.WR_BUSY(busy));
	sebsw_mstr sebsw_mstr_i (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task send(input logic [7:0] b, input logic e);
		q.push_back(e);
		sebsw_mstr_i.wbyte(b);
	endtask
	task wr(input logic [3:0] ty, input logic [2:0] c, input logic [11:0] a, input int n,
		input logic e);
		sebsw_mstr_i.start();
		send({ty, c, 1'b0}, e);
		send({4'($urandom), a[11:8]}, e);
		send(a[7:0], e);
		for (int k = 0; k < n; k++)
			send(d0 + 8'(k), e);
		sebsw_mstr_i.stop();
	endtask
	task idle;
		for (int i = 0; i < 600 && busy !== 1'b0; i++)
			@(posedge clk);
		chk(12'(busy), 12'h000);
	endtask
	task rdpg;
		for (int k = 0; k < 32; k++)
		begin
			@(posedge clk) rd_addr <= 12'h800 + 12'(k);
			repeat (2) @(posedge clk);
			#1 chk(12'(rd_data), 12'(pg[k]));
		end
	endtask
	always @(sebsw_mstr_i.done)
		chk(12'(sebsw_mstr_i.ack_v), 12'(q.pop_front()));
	initial
	begin
		#400us;
		fail_count++;
		summarize();
	end
	initial
	begin
		void'($urandom(32'hb531_b682));
		d0 = 8'($urandom);
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		cs <= 3'($urandom);
		repeat (10) @(posedge clk);
		// 34 bytes from slot 5: the newest 32 stay, pointer wraps in page
		wr(DT, cs, 12'h805, 34, 1'b1);
		for (int k = 0; k < 34; k++)
			pg[(5 + k) % 32] = d0 + 8'(k);
		@(posedge clk) wp <= 1'b1;
		#1 chk(ptr, 12'h807);
		chk(12'(busy), 12'h001);
		// polling while busy gets no ack
		sebsw_mstr_i.start();
		send({DT, cs, 1'b0}, 1'b0);
		sebsw_mstr_i.stop();
		idle();
		rdpg();
		wr(DT, cs, 12'h81F, 1, 1'b1);
		chk(12'(busy), 12'h000);
		rdpg();
		@(posedge clk) wp <= 1'b0;
		wr(DT, cs, 12'h81F, 1, 1'b1);
		pg[31] = d0;
		chk(ptr, 12'h800);
		idle();
		rdpg();
		wr(DT, ~cs, 12'h000, 1, 1'b0);
		wr(DT ^ 4'h8, cs, 12'h000, 1, 1'b0);
		chk(12'(busy), 12'h000);
		sebsw_mstr_i.start();
		send({DT, cs, 1'b1}, 1'b1);
		repeat (8) @(posedge clk);
		chk(12'(rsel), 12'h001);
		chk(12'(ext), 12'(cs));
		sebsw_mstr_i.stop();
		chk(12'(rsel), 12'h000);
		summarize();
	end
endmodule
